// ==== core/rate_volume_spdif_ctrl_regs.v ====
// Rate, volume and digital-output control register bank, AHB-Lite slave.
// Assumes single word transfers; register index times four is the address.
`timescale 1ns/1ns
`include "rate_volume_spdif_ctrl_consts.vh"
module rate_volume_spdif_ctrl_regs
(
   input wire ref_clk_in,
   input wire rstn_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   input wire sample_error_in,
   output wire [15:0] front_rate_out,
   output wire [15:0] surround_rate_out,
   output wire [15:0] center_low_rate_out,
   output wire [15:0] adc_rate_out,
   output wire double_rate_out,
   output wire surround_powerdown_out,
   output wire center_low_powerdown_out,
   output wire [4:0] centre_gain_out,
   output wire centre_mute_out,
   output wire [4:0] low_freq_gain_out,
   output wire low_freq_mute_out,
   output wire [4:0] left_gain_out,
   output wire left_mute_out,
   output wire [4:0] right_gain_out,
   output wire right_mute_out,
   output wire spdif_enable_out,
   output wire [15:0] channel_status_out,
   output wire spdif_tx_rate_select_out,
   output wire validity_flag_out
);
   reg [15:0] front_q;
   reg [15:0] surr_q;
   reg [15:0] clfe_q;
   reg [15:0] adc_q;
   reg [15:0] clfe_vol_q;
   reg [15:0] surr_vol_q;
   reg [15:0] doc_q;
   reg [15:0] ext_q;
   reg wr_pend_q;
   reg [7:0] addr_q;
   reg [31:0] rdata_q;
   reg [15:0] front_d;
   reg [15:0] surr_d;
   reg [15:0] clfe_d;
   reg [15:0] adc_d;
   reg [15:0] clfe_vol_d;
   reg [15:0] surr_vol_d;
   reg [15:0] doc_d;
   reg [15:0] ext_d;
   reg wr_pend_d;
   reg [7:0] addr_d;
   reg [31:0] rdata_d;
   wire take;
   wire wr_now;
   wire vra_d;
   wire [15:0] wd;

   // Word address of a bus byte address.
   function [7:0] word_idx;
      input [31:0] a;
      begin
         word_idx = a[9:2];
      end
   endfunction

   // True when the pending data phase writes the given register.
   function reg_hit;
      input pend;
      input [7:0] idx;
      input [7:0] want;
      begin
         reg_hit = pend && (idx == want);
      end
   endfunction

   // Rate stored value: forced to 48 kHz without variable rate.
   function [15:0] rate_next;
      input [15:0] cur;
      input hit;
      input [15:0] wdat;
      input vra_next;
      begin
         if (!vra_next)
            rate_next = `RATE_48K;
         else if (hit)
            rate_next = wdat;
         else
            rate_next = cur;
      end
   endfunction

   assign take = hsel_in & htrans_in[1] & hready_in;
   assign wr_now = wr_pend_q;
   assign wd = hwdata_in[15:0];
   assign vra_d = ext_d[`EXT_VRA_BIT];

   // A write lands at the edge that ends its data phase.
   always @*
   begin
      wr_pend_d = take & hwrite_in;
      addr_d = addr_q;
      if (take)
         addr_d = word_idx(haddr_in);
   end

   always @*
   begin
      ext_d = ext_q;
      if (reg_hit(wr_now, addr_q, `IDX_EXT_AUDIO_CONTROL))
         ext_d = wd & `EXT_MASK;
   end

   // Rates follow the new variable-rate bit in the same cycle.
   always @*
   begin
      front_d = rate_next(front_q,
         reg_hit(wr_now, addr_q, `IDX_FRONT_DAC_RATE), wd, vra_d);
      surr_d = rate_next(surr_q,
         reg_hit(wr_now, addr_q, `IDX_SURROUND_DAC_RATE), wd, vra_d);
      clfe_d = rate_next(clfe_q,
         reg_hit(wr_now, addr_q, `IDX_CENTER_LOW_DAC_RATE), wd, vra_d);
      adc_d = rate_next(adc_q,
         reg_hit(wr_now, addr_q, `IDX_ADC_RATE), wd, vra_d);
   end

   always @*
   begin
      clfe_vol_d = clfe_vol_q;
      if (reg_hit(wr_now, addr_q, `IDX_CENTER_LOW_VOLUME))
         clfe_vol_d = wd & `VOLUME_MASK;
      surr_vol_d = surr_vol_q;
      if (reg_hit(wr_now, addr_q, `IDX_SURROUND_VOLUME))
         surr_vol_d = wd & `VOLUME_MASK;
      doc_d = doc_q;
      if (reg_hit(wr_now, addr_q, `IDX_DIGITAL_OUT_CONTROL))
         doc_d = wd & `DOC_MASK;
   end

   // Reads see the next values, so a read right behind a write is fresh.
   always @*
   begin
      rdata_d = rdata_q;
      if (take && !hwrite_in)
      begin
         case (word_idx(haddr_in))
            `IDX_FRONT_DAC_RATE: rdata_d = {16'h0000, front_d};
            `IDX_SURROUND_DAC_RATE: rdata_d = {16'h0000, surr_d};
            `IDX_CENTER_LOW_DAC_RATE: rdata_d = {16'h0000, clfe_d};
            `IDX_ADC_RATE: rdata_d = {16'h0000, adc_d};
            `IDX_CENTER_LOW_VOLUME: rdata_d = {16'h0000, clfe_vol_d};
            `IDX_SURROUND_VOLUME: rdata_d = {16'h0000, surr_vol_d};
            `IDX_DIGITAL_OUT_CONTROL: rdata_d = {16'h0000, doc_d};
            `IDX_EXT_AUDIO_CONTROL: rdata_d = {16'h0000, ext_d};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         addr_q <= addr_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ext_q <= `EXT_RESET;
      end
      else
      begin
         ext_q <= ext_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         front_q <= `RATE_48K;
      end
      else
      begin
         front_q <= front_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         surr_q <= `RATE_48K;
      end
      else
      begin
         surr_q <= surr_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         clfe_q <= `RATE_48K;
      end
      else
      begin
         clfe_q <= clfe_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         adc_q <= `RATE_48K;
      end
      else
      begin
         adc_q <= adc_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         clfe_vol_q <= `VOLUME_RESET;
      end
      else
      begin
         clfe_vol_q <= clfe_vol_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         surr_vol_q <= `VOLUME_RESET;
      end
      else
      begin
         surr_vol_q <= surr_vol_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         doc_q <= `DOC_RESET;
      end
      else
      begin
         doc_q <= doc_d;
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rdata_q <= 32'h00000000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign hrdata_out = rdata_q;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   assign front_rate_out = front_q;
   assign surround_rate_out = surr_q;
   assign center_low_rate_out = clfe_q;
   assign adc_rate_out = adc_q;
   assign double_rate_out = ext_q[`EXT_DRA_BIT];
   assign surround_powerdown_out = ext_q[`EXT_DRA_BIT];
   assign center_low_powerdown_out = ext_q[`EXT_DRA_BIT];
   // Centre and LFE fields drive fixed channels; output swap is downstream.
   assign centre_gain_out = clfe_vol_q[4:0];
   assign centre_mute_out = clfe_vol_q[7];
   assign low_freq_gain_out = clfe_vol_q[12:8];
   assign low_freq_mute_out = clfe_vol_q[15];
   assign right_gain_out = surr_vol_q[4:0];
   assign right_mute_out = surr_vol_q[7];
   assign left_gain_out = surr_vol_q[12:8];
   assign left_mute_out = surr_vol_q[15];
   assign spdif_enable_out = ext_q[`EXT_SPDIF_EN_BIT];
   // Low 12 bits: usage class, non-PCM, copy, emphasis, category, level.
   assign channel_status_out = {4'h0, doc_q[11:0]};
   assign spdif_tx_rate_select_out = doc_q[`DOC_RATE_BIT];
   assign validity_flag_out = doc_q[`DOC_VALID_BIT] ? 1'b1 :
      (doc_q[`DOC_VFORCE_BIT] ? 1'b0 : sample_error_in);
endmodule

// ==== core/rate_volume_spdif_ctrl_consts.vh ====
// Register offsets, field positions and reset values of the rate, volume
// and digital-output control registers.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one register per word.
`ifndef RATE_VOLUME_SPDIF_CTRL_CONSTS_VH
`define RATE_VOLUME_SPDIF_CTRL_CONSTS_VH
`define IDX_FRONT_DAC_RATE 8'h2C
`define IDX_SURROUND_DAC_RATE 8'h2E
`define IDX_CENTER_LOW_DAC_RATE 8'h30
`define IDX_ADC_RATE 8'h32
`define IDX_CENTER_LOW_VOLUME 8'h36
`define IDX_SURROUND_VOLUME 8'h38
`define IDX_DIGITAL_OUT_CONTROL 8'h3A
`define IDX_EXT_AUDIO_CONTROL 8'h2A
`define RATE_48K 16'hBB80
`define VOLUME_RESET 16'h8888
`define VOLUME_MASK 16'h9F9F
`define DOC_RESET 16'h2000
`define DOC_MASK 16'hEFFF
`define EXT_MASK 16'h0007
`define EXT_RESET 16'h0000
`define EXT_VRA_BIT 0
`define EXT_DRA_BIT 1
`define EXT_SPDIF_EN_BIT 2
`define DOC_VALID_BIT 15
`define DOC_VFORCE_BIT 14
`define DOC_RATE_BIT 13
`endif

// ==== tb/rate_volume_spdif_ctrl_checker.sv ====
// Assertions on the rate, volume and digital-output register bank.
// Bound to the bank and sees only its ports.
`timescale 1ns/1ns
module rate_volume_spdif_ctrl_checker
(
   input wire ref_clk_in,
   input wire rstn_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire hready_in,
   input wire sample_error_in,
   input wire [15:0] front_rate_out,
   input wire [15:0] channel_status_out,
   input wire [4:0] centre_gain_out,
   input wire centre_mute_out,
   input wire left_mute_out,
   input wire double_rate_out,
   input wire surround_powerdown_out,
   input wire validity_flag_out
);
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);
   logic [7:0] wa1_q;
   logic [7:0] wa2_q;
   // Byte address of the write whose data landed at the last edge.
   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         wa1_q <= 8'hFF;
         wa2_q <= 8'hFF;
      end
      else
      begin
         wa1_q <= (hsel_in && htrans_in[1] && hwrite_in && hready_in) ?
            haddr_in[7:0] : 8'hFF;
         wa2_q <= wa1_q;
      end
   end
   a_pd_follow: assert property
      (surround_powerdown_out == double_rate_out) else $error("powerdown");
   a_reset_vals: assert property
      ($rose(rstn_in) |-> centre_mute_out && left_mute_out
         && front_rate_out == 16'hBB80) else $error("reset values");
   a_rate_cause: assert property
      ($changed(front_rate_out) |-> wa2_q == 8'hB0
         || wa2_q == 8'hA8) else $error("rate change");
   a_dra_cause: assert property
      ($changed(double_rate_out) |-> wa2_q == 8'hA8) else $error("dra");
   a_gain_cause: assert property
      ($changed(centre_gain_out) |-> wa2_q == 8'hD8) else $error("gain");
   a_mute_cause: assert property
      ($changed(left_mute_out) |-> wa2_q == 8'hE0) else $error("mute");
   a_status_cause: assert property
      ($changed(channel_status_out) |-> wa2_q == 8'hE8)
      else $error("status");
   a_valid_cause: assert property
      ($changed(validity_flag_out) |-> $changed(sample_error_in)
         || wa2_q == 8'hE8) else $error("validity");
endmodule
bind rate_volume_spdif_ctrl_regs rate_volume_spdif_ctrl_checker chk_u (.*);

// ==== tb/host_bus_model.sv ====
// Host side: single-word AHB-Lite master, one transfer per xfer call.
// Released address and data lines show the inverse of their last value.
`timescale 1ns/1ns
module host_bus_model
(
   input wire ref_clk_in,
   input wire hready_in,
   input wire [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output wire [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   assign hsize_out = 3'h2;
   initial
   begin
      {hsel_out, haddr_out, htrans_out, hwrite_out, hwdata_out} = '0;
   end
   task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge ref_clk_in);
      hsel_out <= 1'b1;
      haddr_out <= a;
      htrans_out <= 2'h2;
      hwrite_out <= w;
      do @(posedge ref_clk_in); while (!hready_in);
      hsel_out <= 1'b0;
      htrans_out <= 2'h0;
      haddr_out <= ~a;
      hwdata_out <= d;
      do @(posedge ref_clk_in); while (!hready_in);
      r = hrdata_in;
      hwdata_out <= ~d;
   endtask
endmodule

// ==== tb/rate_volume_spdif_ctrl_regs_tb.sv ====
// Self-checking bench for the rate, volume and digital-output bank.
// Drives it through the host bus model; the checker is bound.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %0t %h %h", $time, g, e); end end
module rate_volume_spdif_ctrl_regs_tb;
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic sample_error_in = 1'b0;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] rd;
   wire hsel_in, hwrite_in, hreadyout_out, hresp_out, hready_in;
   wire [31:0] haddr_in, hwdata_in, hrdata_out;
   wire [1:0] htrans_in;
   wire [2:0] hsize_in;
   wire [15:0] front_rate_out, surround_rate_out, adc_rate_out;
   wire [15:0] center_low_rate_out, channel_status_out;
   wire [4:0] centre_gain_out, low_freq_gain_out, left_gain_out, right_gain_out;
   wire double_rate_out, surround_powerdown_out, center_low_powerdown_out;
   wire centre_mute_out, low_freq_mute_out, left_mute_out, right_mute_out;
   wire spdif_enable_out, spdif_tx_rate_select_out, validity_flag_out;
   // Row: write flag, address, write data, expected read data.
   logic [43:0] rows [12] = '{44'h0D800008888,
      44'h0E800002000,
      44'h1B01B58BB80, 44'h1A800010001,
      44'h1B01B581B58, 44'h1B856225622,
      44'h1C8AC44AC44, 44'h1D8FFFF9F9F,
      44'h1C01F401F40,
      44'h1E000800080, 44'h1E8FFFFEFFF,
      44'h1F012340000};
   assign hready_in = hreadyout_out;
   rate_volume_spdif_ctrl_regs dut_u (.*);
   host_bus_model host_u (.ref_clk_in, .hready_in, .hrdata_in(hrdata_out),
      .hsel_out(hsel_in), .haddr_out(haddr_in), .htrans_out(htrans_in),
      .hwrite_out(hwrite_in), .hsize_out(hsize_in), .hwdata_out(hwdata_in));
   initial forever #20 ref_clk_in = ~ref_clk_in;
   task stop_test;
      if (err_total == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         stop_test;
      end
   end
   task wr(input logic [7:0] a, input logic [15:0] d);
      host_u.xfer(1'b1, {24'h0, a}, {16'h0, d}, rd);
      @(negedge ref_clk_in);
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i][40]) wr(rows[i][39:32], rows[i][31:16]);
         host_u.xfer(1'b0, {24'h0, rows[i][39:32]}, 32'h0, rd);
         `CHK(rd, {16'h0, rows[i][15:0]})
      end
      `CHK(centre_gain_out, 5'h1F)
      `CHK({left_mute_out, right_mute_out}, 2'h1)
      `CHK({spdif_tx_rate_select_out, validity_flag_out}, 2'h3)
      `CHK(channel_status_out, 16'h0FFF)
      `CHK({left_gain_out, right_gain_out}, 10'h000)
      `CHK(low_freq_gain_out, 5'h1F)
      `CHK(surround_rate_out, 16'h5622)
      `CHK(center_low_rate_out, 16'h1F40)
      `CHK(spdif_enable_out, 1'b0)
      `CHK({hresp_out, hreadyout_out}, 2'h1)
      wr(8'hE8, 16'h4000);
      @(posedge ref_clk_in) sample_error_in <= 1'b1;
      @(negedge ref_clk_in);
      `CHK(validity_flag_out, 1'b0)
      wr(8'hE8, 16'h0000);
      `CHK({spdif_tx_rate_select_out, validity_flag_out}, 2'h1)
      wr(8'hA8, 16'h0002);
      `CHK({front_rate_out, double_rate_out}, {16'hBB80, 1'b1})
      `CHK({surround_powerdown_out, center_low_powerdown_out}, 2'h3)
      `CHK(adc_rate_out, 16'hBB80)
      @(posedge ref_clk_in) rstn_in <= 1'b0;
      @(negedge ref_clk_in);
      `CHK({front_rate_out, adc_rate_out}, {16'hBB80, 16'hBB80})
      `CHK({centre_mute_out, low_freq_mute_out}, 2'h3)
      `CHK({left_mute_out, right_mute_out}, 2'h3)
      `CHK({double_rate_out, spdif_tx_rate_select_out}, 2'h1)
      `CHK(channel_status_out, 16'h0000)
      repeat (2) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      host_u.xfer(1'b0, 32'h000000E8, 32'h0, rd);
      `CHK(rd, 32'h00002000)
      stop_test;
   end
endmodule
